// ==== design/blc_chan.sv ====
// one colour channel: running frame average and automatic offset
`timescale 1ns/1ns
module blc_chan (
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic       frame_i,
  input  wire logic       load_i,
  input  wire logic [7:0] step_i,
  input  wire logic [6:0] new_i,
  input  wire logic [2:0] depth_i,
  input  wire logic [6:0] lo_i,
  input  wire logic [6:0] hi_i,
  output logic      [8:0] off_o,
  output logic      [6:0] avg_o
);

  // ==========================================================================
  // running average, kept with fraction bits so small updates are not lost
  logic [13:0] acc_reg;
  logic [13:0] acc_next;
  logic [13:0] new_fx;
  logic [8:0]  off_reg;
  logic [8:0]  off_next;
  logic [6:0]  avg_now;

  always_comb begin
    new_fx   = {new_i, {blc_pkg::FRAC_W{1'b0}}};
    acc_next = acc_reg;
    if (frame_i) begin
      if (load_i) begin
        acc_next = new_fx;
      end else begin
        acc_next = acc_reg - (acc_reg >> depth_i) + (new_fx >> depth_i);
      end
    end
    avg_now  = acc_next[13:7];
    off_next = off_reg;
    if (frame_i && (step_i != blc_pkg::STEP_NONE)) begin
      // below target raises the offset, above target lowers it
      if (avg_now < lo_i) begin
        off_next = blc_pkg::blc_sat_step(off_reg, step_i, 1'b1);
      end else if (avg_now > hi_i) begin
        off_next = blc_pkg::blc_sat_step(off_reg, step_i, 1'b0);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_reg <= 14'h0000;
      off_reg <= 9'h000;
    end else begin
      acc_reg <= acc_next;
      off_reg <= off_next;
    end
  end

  assign off_o = off_reg;
  assign avg_o = acc_reg[13:7];

  // ==========================================================================
  // checks
  a_avg_reload: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (frame_i && load_i) |=> (avg_o == $past(new_i)))
    else $error("recalculate did not reload the average");

  a_avg_depth_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (frame_i && !load_i && (depth_i == 3'h0)) |=> (avg_o == $past(new_i)))
    else $error("depth zero average is not the new frame");

endmodule

// ==== design/blc_ctrl.sv ====
// black level calibration control, offset registers and apb slave
// Behaviour
// - average black level over two to the depth field frames; depth resets to four
// - per frame: average minus average over 2^n plus new over 2^n
// - sweep bit ramps one common value up by one each frame
// - writing recalculate starts rapid sweep when rapid sweep is enabled
// - writing recalculate reloads the running average with the current frame
// - recalculate acts on writing one and always reads zero
// - rapid-sweep disable bit keeps rapid sweep from running
// - with rapid sweep disabled frame averaging still runs
// - offsets are 9 bits; bit 8 clear means positive magnitude 7:0
// - bit 8 set means negative, magnitude is inverse of 7:0 plus one
// - without manual override offset writes are ignored, reads give computed value
// - with manual override written offsets are applied to their channel
// - green1 offset drives greens on the rows carrying red
// - blue channel has its own offset register beside green1 and red
// - control bit 0 selects programmed offsets; resets to zero
// - same-green bit gives green2 pixels the green1 value
// - same-red-blue bit gives blue pixels the red value
// - target lies between 7-bit lower and upper thresholds, reset 1D and 23
`timescale 1ns/1ns
module blc_ctrl (
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [11:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic              frame_start_i,
  input  wire blc_pkg::blc_avg_t frame_avg_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output blc_pkg::blc_cal_t      cal_o,
  output logic                   bad_frame_o
);

  // ==========================================================================
  // declarations
  logic [9:0]           idx;
  logic                 setup;
  logic                 wr;
  logic                 hit;
  logic [31:0]          prdata_reg;
  logic [31:0]          prdata_next;
  logic                 pready_reg;
  logic                 pready_next;
  logic                 pslverr_reg;
  logic                 pslverr_next;

  blc_pkg::blc_ctrl_t   ctrl_reg;
  blc_pkg::blc_ctrl_t   ctrl_next;
  blc_pkg::blc_thresh_t thr_reg;
  blc_pkg::blc_thresh_t thr_next;
  blc_pkg::blc_man_t    man_reg;
  blc_pkg::blc_man_t    man_next;
  logic                 recalc_pend_reg;
  logic                 recalc_pend_next;
  logic                 dis_eff_reg;
  logic                 dis_eff_next;

  blc_pkg::blc_state_t  state_reg;
  blc_pkg::blc_state_t  state_next;
  logic [7:0]           step_reg;
  logic [7:0]           step_next;
  logic [7:0]           chan_step;
  logic [8:0]           sweep_reg;
  logic [8:0]           sweep_next;
  blc_pkg::blc_cal_t    cal_reg;
  blc_pkg::blc_cal_t    cal_next;
  logic                 bad_reg;
  logic                 bad_next;
  logic                 fs_q_reg;
  logic                 chg;
  logic                 reload;

  blc_pkg::blc_off_t    auto_off [blc_pkg::NUM_CH];

  // ==========================================================================
  // apb slave: one access cycle, answer registered in setup
  assign idx   = paddr_i[11:blc_pkg::ADDR_LSB];
  assign setup = psel_i && !penable_i;
  assign wr    = psel_i && penable_i && pready_reg && pwrite_i;

  always_comb begin
    hit = (idx == blc_pkg::IDX_THRESH) || (idx == blc_pkg::IDX_CTRL) ||
          (idx == blc_pkg::IDX_GREEN1) || (idx == blc_pkg::IDX_BLUE) ||
          (idx == blc_pkg::IDX_RED)    || (idx == blc_pkg::IDX_STATUS);
    pready_next  = setup;
    pslverr_next = setup && !hit;
    prdata_next  = 32'h0000_0000;
    if (setup && !pwrite_i) begin
      case (idx)
        blc_pkg::IDX_THRESH: prdata_next[15:0] = thr_reg;
        blc_pkg::IDX_CTRL:   prdata_next[15:0] = ctrl_reg;
        // computed value unless override is on
        blc_pkg::IDX_GREEN1: prdata_next[8:0] = ctrl_reg.manual ?
                               man_reg[blc_pkg::CH_G1] : auto_off[blc_pkg::CH_G1];
        blc_pkg::IDX_BLUE:   prdata_next[8:0] = ctrl_reg.manual ?
                               man_reg[blc_pkg::CH_B] : auto_off[blc_pkg::CH_B];
        blc_pkg::IDX_RED:    prdata_next[8:0] = ctrl_reg.manual ?
                               man_reg[blc_pkg::CH_R] : auto_off[blc_pkg::CH_R];
        blc_pkg::IDX_STATUS: prdata_next[2:0] = {dis_eff_reg,
                               (state_reg == blc_pkg::ST_RAPID), bad_reg};
        default:             prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ==========================================================================
  // control, thresholds and manual offsets
  always_comb begin
    ctrl_next = ctrl_reg;
    thr_next  = thr_reg;
    man_next  = man_reg;
    if (wr && (idx == blc_pkg::IDX_CTRL)) begin
      // recalculate is never stored, so it reads back as zero
      ctrl_next = blc_pkg::blc_ctrl_t'(pwdata_i[15:0] & blc_pkg::CTRL_WMASK);
    end
    if (wr && (idx == blc_pkg::IDX_THRESH)) begin
      thr_next = blc_pkg::blc_thresh_t'(pwdata_i[15:0] & blc_pkg::THRESH_MASK);
    end
    for (int c = 0; c < blc_pkg::NUM_MAN; c++) begin
      // tracking the computed value keeps the switch to override seamless
      if (!ctrl_reg.manual) begin
        man_next[c] = auto_off[c];
      end
    end
    if (ctrl_reg.manual && wr) begin
      case (idx)
        blc_pkg::IDX_GREEN1: man_next[blc_pkg::CH_G1] = pwdata_i[8:0];
        blc_pkg::IDX_BLUE:   man_next[blc_pkg::CH_B]  = pwdata_i[8:0];
        blc_pkg::IDX_RED:    man_next[blc_pkg::CH_R]  = pwdata_i[8:0];
        default:             man_next = man_next;
      endcase
    end
    // a write in the frame start cycle still counts for the next frame
    recalc_pend_next = (recalc_pend_reg && !frame_start_i) ||
                       (wr && (idx == blc_pkg::IDX_CTRL) && pwdata_i[12]);
    dis_eff_next     = frame_start_i ? ctrl_reg.dis_rapid : dis_eff_reg;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_reg        <= blc_pkg::blc_ctrl_t'(blc_pkg::CTRL_RST);
      thr_reg         <= blc_pkg::blc_thresh_t'(blc_pkg::THRESH_RST);
      man_reg         <= '0;
      recalc_pend_reg <= 1'b0;
      dis_eff_reg     <= 1'b0;
    end else begin
      ctrl_reg        <= ctrl_next;
      thr_reg         <= thr_next;
      man_reg         <= man_next;
      recalc_pend_reg <= recalc_pend_next;
      dis_eff_reg     <= dis_eff_next;
    end
  end

  // ==========================================================================
  // per channel averaging and automatic offsets
  assign reload = frame_start_i && recalc_pend_reg;

  for (genvar g = 0; g < blc_pkg::NUM_CH; g++) begin : g_chan
    blc_chan u_chan (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .frame_i   (frame_start_i),
      .load_i    (reload),
      .step_i    (chan_step),
      .new_i     (frame_avg_i[g]),
      .depth_i   (ctrl_reg.depth),
      .lo_i      (thr_reg.lower),
      .hi_i      (thr_reg.upper),
      .off_o     (auto_off[g]),
      .avg_o     ()
    );
  end

  // ==========================================================================
  // rapid sweep sequencer, sweep ramp and applied offsets
  always_comb begin
    state_next = state_reg;
    step_next  = step_reg;
    case (state_reg)
      blc_pkg::ST_AVG: begin
        if (reload && !ctrl_reg.dis_rapid && !ctrl_reg.sweep) begin
          state_next = blc_pkg::ST_RAPID;
          step_next  = ctrl_reg.step_one ? blc_pkg::STEP_ONE : blc_pkg::RAPID_STEP_INIT;
        end
      end
      blc_pkg::ST_RAPID: begin
        if (frame_start_i) begin
          if (ctrl_reg.dis_rapid || ctrl_reg.sweep) begin
            state_next = blc_pkg::ST_AVG;
          end else if (reload) begin
            step_next = ctrl_reg.step_one ? blc_pkg::STEP_ONE : blc_pkg::RAPID_STEP_INIT;
          end else if (step_reg <= blc_pkg::STEP_ONE) begin
            state_next = blc_pkg::ST_AVG;
          end else begin
            step_next = step_reg >> 1;
          end
        end
      end
      default: begin
        state_next = blc_pkg::ST_AVG;
        step_next  = blc_pkg::STEP_NONE;
      end
    endcase

    // offset steps stop while override or sweep owns the offsets; averaging keeps running
    if (ctrl_reg.manual || ctrl_reg.sweep) begin
      chan_step = blc_pkg::STEP_NONE;
    end else if (state_reg == blc_pkg::ST_RAPID) begin
      chan_step = step_reg;
    end else begin
      chan_step = blc_pkg::STEP_ONE;
    end

    if (!ctrl_reg.sweep) begin
      sweep_next = 9'h000;
    end else if (frame_start_i) begin
      sweep_next = sweep_reg + 9'h001;
    end else begin
      sweep_next = sweep_reg;
    end

    for (int c = 0; c < blc_pkg::NUM_CH; c++) begin
      if (ctrl_reg.sweep) begin
        cal_next[c] = sweep_reg;
      end else if (ctrl_reg.manual && (c < blc_pkg::NUM_MAN)) begin
        cal_next[c] = man_reg[c];
      end else begin
        cal_next[c] = auto_off[c];
      end
    end
    // green1 output serves greens on red rows; green2 slot serves blue rows
    if (ctrl_reg.same_green) begin
      cal_next[blc_pkg::CH_G2] = cal_next[blc_pkg::CH_G1];
    end
    if (ctrl_reg.same_rb) begin
      cal_next[blc_pkg::CH_B] = cal_next[blc_pkg::CH_R];
    end

    // updates landing just after frame start are between frames, not bad
    chg      = (cal_next != cal_reg);
    bad_next = (chg && !fs_q_reg) || (bad_reg && !frame_start_i);
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= blc_pkg::ST_AVG;
      step_reg  <= blc_pkg::STEP_NONE;
      sweep_reg <= 9'h000;
      cal_reg   <= '0;
      bad_reg   <= 1'b0;
      fs_q_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      step_reg  <= step_next;
      sweep_reg <= sweep_next;
      cal_reg   <= cal_next;
      bad_reg   <= bad_next;
      fs_q_reg  <= frame_start_i;
    end
  end

  assign prdata_o    = prdata_reg;
  assign pready_o    = pready_reg;
  assign pslverr_o   = pslverr_reg;
  assign cal_o       = cal_reg;
  assign bad_frame_o = bad_reg;

  // ==========================================================================
  // checks
  a_recalc_reads_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (setup && !pwrite_i && (idx == blc_pkg::IDX_CTRL)) |=> (pready_o && !prdata_o[12]))
    else $error("recalculate bit read back as one");

  a_rapid_start: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (reload && !ctrl_reg.dis_rapid && !ctrl_reg.sweep)
      |=> (state_reg == blc_pkg::ST_RAPID))
    else $error("recalculate did not start rapid sweep");

  a_rapid_blocked: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_reg == blc_pkg::ST_RAPID) |-> !dis_eff_reg)
    else $error("rapid sweep runs while disabled");

  a_sweep_ramp: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ctrl_reg.sweep && frame_start_i) |=> (sweep_reg == $past(sweep_reg) + 9'h001))
    else $error("sweep value did not step by one");

  a_sweep_equal: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $past(ctrl_reg.sweep) |-> ((cal_o[0] == cal_o[1]) && (cal_o[1] == cal_o[2]) &&
                               (cal_o[2] == cal_o[3])))
    else $error("sweep channels differ");

  a_same_green: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $past(ctrl_reg.same_green) |-> (cal_o[blc_pkg::CH_G2] == cal_o[blc_pkg::CH_G1]))
    else $error("green2 does not follow green1");

  a_same_rb: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $past(ctrl_reg.same_rb) |-> (cal_o[blc_pkg::CH_B] == cal_o[blc_pkg::CH_R]))
    else $error("blue does not follow red");

  a_manual_apply: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ($past(ctrl_reg.manual) && !$past(ctrl_reg.sweep))
      |-> (cal_o[blc_pkg::CH_G1] == $past(man_reg[blc_pkg::CH_G1])))
    else $error("manual green1 offset not applied");

  a_bad_frame: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (chg && !fs_q_reg) |=> bad_frame_o [*1] ##0 (bad_frame_o || $past(frame_start_i)))
    else $error("offset change did not mark the frame bad");

endmodule

// ==== design/blc_pkg.sv ====
// constants, types and helpers for the black level calibration block
package blc_pkg;

  // ==========================================================================
  // register word indices (byte address is index times four)
  localparam logic [9:0] IDX_THRESH = 10'h05F;
  localparam logic [9:0] IDX_CTRL   = 10'h060;
  localparam logic [9:0] IDX_GREEN1 = 10'h061;
  localparam logic [9:0] IDX_BLUE   = 10'h062;
  localparam logic [9:0] IDX_RED    = 10'h063;
  localparam logic [9:0] IDX_STATUS = 10'h065;
  localparam int         ADDR_LSB   = 2;

  // ==========================================================================
  // field layouts and reset values
  typedef struct packed {
    logic       dis_rapid;
    logic [1:0] rsv_hi;
    logic       recalc;
    logic [2:0] rsv_mid;
    logic       sweep;
    logic [2:0] depth;
    logic       step_one;
    logic       rsv_lo;
    logic       same_rb;
    logic       same_green;
    logic       manual;
  } blc_ctrl_t;

  typedef struct packed {
    logic       rsv_hi;
    logic [6:0] upper;
    logic       rsv_lo;
    logic [6:0] lower;
  } blc_thresh_t;

  localparam logic [15:0] CTRL_RST    = 16'h0080;
  localparam logic [15:0] CTRL_WMASK  = 16'h81F7;
  localparam logic [15:0] THRESH_RST  = 16'h231D;
  localparam logic [15:0] THRESH_MASK = 16'h7F7F;

  // ==========================================================================
  // channels: green1, blue, red carry registers; green2 is internal only
  localparam int CH_G1  = 0;
  localparam int CH_B   = 1;
  localparam int CH_R   = 2;
  localparam int CH_G2  = 3;
  localparam int NUM_CH = 4;
  localparam int NUM_MAN = 3;

  typedef logic [8:0]                 blc_off_t;
  typedef logic [NUM_CH-1:0][6:0]     blc_avg_t;
  typedef logic [NUM_CH-1:0][8:0]     blc_cal_t;
  typedef logic [NUM_MAN-1:0][8:0]    blc_man_t;

  typedef enum logic [1:0] {
    ST_AVG   = 2'b00,
    ST_RAPID = 2'b01
  } blc_state_t;

  // ==========================================================================
  // timing and arithmetic constants
  localparam logic [7:0] RAPID_STEP_INIT = 8'h08;
  localparam logic [7:0] STEP_ONE        = 8'h01;
  localparam logic [7:0] STEP_NONE       = 8'h00;
  localparam int         FRAC_W          = 7;
  localparam logic [8:0] OFF_MAX         = 9'h0FF;
  localparam logic [8:0] OFF_MIN         = 9'h100;

  // saturating move of a 9-bit two's complement offset
  function automatic blc_off_t blc_sat_step(input blc_off_t off, input logic [7:0] step,
                                            input logic up);
    logic [9:0] delta;
    logic [9:0] sum;
    delta = up ? {2'b00, step} : (~{2'b00, step} + 10'h001);
    sum   = {off[8], off} + delta;
    if (sum[9] != sum[8]) begin
      blc_sat_step = sum[9] ? OFF_MIN : OFF_MAX;
    end else begin
      blc_sat_step = sum[8:0];
    end
  endfunction

endpackage

// ==== tb/tb_top.sv ====
// self-checking testbench for the black level calibration control block
`timescale 1ns/1ns
module tb_top;
  // ==========================================================================
  // clock, reset and design inputs
  logic              clk_sys_i = 1'b0;
  logic              rstn_i = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic              frame_start = 1'b0;
  blc_pkg::blc_avg_t frame_avg = '0;
  logic [31:0]       prdata_o;
  logic              pready_o;
  logic              pslverr_o;
  blc_pkg::blc_cal_t cal_o;
  logic              bad_frame_o;
  int                error_cnt = 0;
  int                check_count = 0;

  always #25 clk_sys_i = ~clk_sys_i;

  blc_ctrl dut (
    .clk_sys_i     (clk_sys_i),
    .rstn_i        (rstn_i),
    .psel_i        (psel),
    .penable_i     (penable),
    .pwrite_i      (pwrite),
    .paddr_i       (paddr),
    .pwdata_i      (pwdata),
    .frame_start_i (frame_start),
    .frame_avg_i   (frame_avg),
    .prdata_o      (prdata_o),
    .pready_o      (pready_o),
    .pslverr_o     (pslverr_o),
    .cal_o         (cal_o),
    .bad_frame_o   (bad_frame_o)
  );

  // ==========================================================================
  // shared tasks
  task automatic give_verdict();
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask

  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic is_wr, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= is_wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    err = pslverr_o;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      $display("unexpected pready timeout expected 1 seen 0");
      error_cnt++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, wd, rd, err);
  endtask

  task automatic rd_chk(input string name, input logic [9:0] idx, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, idx, 32'h0000_0000, rd, err);
    chk(name, exp, rd);
    chk({name, " error"}, {31'h0, exp_err}, {31'h0, err});
  endtask

  // one frame start pulse, every channel at the given black level
  task automatic frame_at(input logic [6:0] lvl);
    @(posedge clk_sys_i);
    frame_start <= 1'b1;
    frame_avg   <= {blc_pkg::NUM_CH{lvl}};
    @(posedge clk_sys_i);
    frame_start <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask

  // all channels well below the lower threshold
  task automatic frame();
    frame_at(7'h00);
  endtask

  task automatic do_reset();
    rstn_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
  endtask

  // ==========================================================================
  // scenarios
  task automatic sc_reset_values();
    rd_chk("control", blc_pkg::IDX_CTRL, 32'h0000_0080, 1'b0);
    rd_chk("thresholds", blc_pkg::IDX_THRESH, 32'h0000_231D, 1'b0);
    rd_chk("green1", blc_pkg::IDX_GREEN1, 32'h0000_0000, 1'b0);
    rd_chk("unmapped", 10'h3FF, 32'h0000_0000, 1'b1);
  endtask

  task automatic sc_manual();
    wr(blc_pkg::IDX_GREEN1, 32'h0000_0155);
    rd_chk("green1 locked", blc_pkg::IDX_GREEN1, 32'h0000_0000, 1'b0);
    wr(blc_pkg::IDX_CTRL, 32'h0000_0081);
    wr(blc_pkg::IDX_GREEN1, 32'h0000_01F0);
    wr(blc_pkg::IDX_BLUE, 32'h0000_0010);
    wr(blc_pkg::IDX_RED, 32'h0000_01FF);
    repeat (2) @(posedge clk_sys_i);
    chk("cal green1", 32'h0000_01F0, {23'h0, cal_o[0]});
    chk("cal blue", 32'h0000_0010, {23'h0, cal_o[1]});
    chk("cal red", 32'h0000_01FF, {23'h0, cal_o[2]});
    chk("bad frame", 32'h0000_0001, {31'h0, bad_frame_o});
    rd_chk("red readback", blc_pkg::IDX_RED, 32'h0000_01FF, 1'b0);
    wr(blc_pkg::IDX_CTRL, 32'h0000_1087);
    repeat (2) @(posedge clk_sys_i);
    chk("cal green2", 32'h0000_01F0, {23'h0, cal_o[3]});
    chk("cal blue shared", 32'h0000_01FF, {23'h0, cal_o[1]});
    rd_chk("recalc reads zero", blc_pkg::IDX_CTRL, 32'h0000_0087, 1'b0);
    frame();
    chk("bad frame cleared", 32'h0000_0000, {31'h0, bad_frame_o});
  endtask

  task automatic sc_sweep();
    wr(blc_pkg::IDX_CTRL, 32'h0000_0180);
    repeat (3) frame();
    for (int ch = 0; ch < blc_pkg::NUM_CH; ch++) begin
      chk("sweep value", 32'h0000_0003, {23'h0, cal_o[ch]});
    end
  endtask

  // rapid disabled: recalc reloads the average, steps stay one per frame
  task automatic sc_averaging();
    logic [8:0] o1;
    wr(blc_pkg::IDX_CTRL, 32'h0000_9080);
    frame();
    frame();
    o1 = cal_o[0];
    frame();
    chk("avg step", {23'h0, o1 + 9'h001}, {23'h0, cal_o[0]});
  endtask

  task automatic sc_rapid();
    logic [8:0] o1;
    wr(blc_pkg::IDX_CTRL, 32'h0000_1080);
    frame();
    o1 = cal_o[0];
    frame();
    chk("rapid first step", {23'h0, o1 + 9'h008}, {23'h0, cal_o[0]});
    frame();
    chk("rapid second step", {23'h0, o1 + 9'h00C}, {23'h0, cal_o[0]});
    // recalculate inside rapid sweep restarts the large step
    wr(blc_pkg::IDX_CTRL, 32'h0000_1080);
    frame();
    frame();
    chk("rapid restart", {23'h0, o1 + 9'h016}, {23'h0, cal_o[0]});
    // forced step of one replaces the large first step
    wr(blc_pkg::IDX_CTRL, 32'h0000_1090);
    frame();
    frame();
    chk("rapid step one", {23'h0, o1 + 9'h01B}, {23'h0, cal_o[0]});
  endtask

  // high then low levels at depths 0 and 1, then a recalculate reload
  task automatic sc_depth();
    wr(blc_pkg::IDX_THRESH, 32'h0000_A090);
    rd_chk("thresholds written", blc_pkg::IDX_THRESH, 32'h0000_2010, 1'b0);
    wr(blc_pkg::IDX_CTRL, 32'h0000_8000);
    rd_chk("status before frame", blc_pkg::IDX_STATUS, 32'h0000_0000, 1'b0);
    frame_at(7'h7F);
    chk("cal red depth zero", 32'h0000_01FF, {23'h0, cal_o[2]});
    rd_chk("status after frame", blc_pkg::IDX_STATUS, 32'h0000_0004, 1'b0);
    wr(blc_pkg::IDX_CTRL, 32'h0000_8020);
    frame_at(7'h01);
    chk("cal red depth one", 32'h0000_01FE, {23'h0, cal_o[2]});
    wr(blc_pkg::IDX_CTRL, 32'h0000_9080);
    frame_at(7'h01);
    chk("cal red reloaded", 32'h0000_01FF, {23'h0, cal_o[2]});
    rd_chk("status no rapid", blc_pkg::IDX_STATUS, 32'h0000_0004, 1'b0);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    do_reset();
    sc_reset_values();
    sc_manual();
    do_reset();
    sc_sweep();
    do_reset();
    sc_averaging();
    do_reset();
    sc_rapid();
    do_reset();
    sc_depth();
    give_verdict();
  end
endmodule
